// ==== design/cpuam_decoder.sv ====
// Addressing mode decoder: prefix handling, operand fetch, address forming
`timescale 1ns/10ps
// How it works
// - Seventeen addressing modes in seven groups are decoded and sequenced.
// - Short forms reach page zero, short indexed ones up to 1FE; long forms reach all 64 Kbytes.
// - Memory-to-memory operations with a long form are flagged illegal.
// - Inherent mode fetches no byte after the opcode.
// - Immediate mode fetches one byte and hands it out as operand.
// - Short direct uses the one byte after the opcode as address.
// - Long direct uses the two bytes after the opcode as address.
// - Indexed address is the unsigned sum of index and offset.
// - Indexed without offset uses the index register alone.
// - Short indexed adds a one-byte offset, reaching up to 1FE.
// - Long indexed adds a two-byte offset to the index register.
// - Indirect modes read the effective address at the pointer.
// - Short indirect reads a byte pointer from page zero.
// - Long indirect forms read a word pointer from page zero.
// - Indirect indexed adds index register to the pointer value.
// - Short indirect indexed adds index to a byte pointer, to 1FE.
// - Relative modes add a signed 8-bit offset to the program counter.
// - Prefix 90 swaps the first index register for the second.
// - Prefix 92 turns direct forms and the offset indexed forms into indirect ones.
// - Prefix 91 gives indirect indexed with the second index register.
module cpuam_decoder
  import cpuam_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  mode_i,
  input  wire logic [7:0]  prefix_i,
  input  wire logic        mem_op_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  x_i,
  input  wire logic [7:0]  y_i,
  output logic             mem_req_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        mem_ack_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic             use_y_o,
  output logic [4:0]       mode_o,
  output logic [15:0]      ea_o,
  output logic [15:0]      target_o,
  output logic [7:0]       operand_o,
  output logic [1:0]       len_o
);

  // Prefix translation of the mode the opcode implies
  function automatic cpuam_mode_t prefix_remap(input cpuam_mode_t m,
                                               input logic [7:0] p);
    prefix_remap = m;
    if (p == CPUAM_PFX_INDIRECT) begin
      case (m)
        AM_DIR_S:    prefix_remap = AM_IND_S;
        AM_DIR_L:    prefix_remap = AM_IND_L;
        AM_REL_D:    prefix_remap = AM_REL_I;
        AM_BIT_D:    prefix_remap = AM_BIT_I;
        AM_BITREL_D: prefix_remap = AM_BITREL_I;
        AM_IDX_S:    prefix_remap = AM_INDIDX_S;
        AM_IDX_L:    prefix_remap = AM_INDIDX_L;
        default:     prefix_remap = m;
      endcase
    end else if (p == CPUAM_PFX_ALT_IND_IDX) begin
      case (m)
        AM_IDX_S:    prefix_remap = AM_INDIDX_S;
        AM_IDX_L:    prefix_remap = AM_INDIDX_L;
        default:     prefix_remap = m;
      endcase
    end
  endfunction

  cpuam_state_t state_r;
  cpuam_state_t state_nxt;
  cpuam_mode_t  req_mode;
  cpuam_mode_t  eff_mode;
  cpuam_mode_t  mode_r;
  logic         is_x_indexed;
  logic         is_ind_idx;
  logic         sel_y;
  logic         long_bad;
  logic         no_fetch;
  logic         accept;
  logic         take_b1;
  logic         take_b2;
  logic         take_p1;
  logic         take_p2;
  logic [7:0]   idx_r;
  logic [15:0]  pc_r;
  logic [7:0]   b1_r;
  logic [7:0]   b2_r;
  logic [7:0]   p1_r;
  logic [7:0]   p2_r;
  logic         bad_r;
  logic         use_y_r;
  logic [15:0]  calc_ea;
  logic [15:0]  calc_target;
  logic [1:0]   calc_len;
  logic [15:0]  ea_r;
  logic [15:0]  target_r;
  logic [7:0]   operand_r;
  logic [1:0]   len_r;
  logic         done_r;
  logic         illegal_r;
  logic [4:0]   mode_out_r;
  logic         use_y_out_r;
  logic [15:0]  pc_next;
  logic [7:0]   b1_next;
  logic [15:0]  addr_nxt;
  logic [15:0]  addr_r;

  assign req_mode     = cpuam_mode_t'(mode_i);
  assign eff_mode     = prefix_remap(req_mode, prefix_i);
  assign is_x_indexed = (eff_mode == AM_IDX0) || (eff_mode == AM_IDX_S) ||
                        (eff_mode == AM_IDX_L);
  assign is_ind_idx   = (eff_mode == AM_INDIDX_S) ||
                        (eff_mode == AM_INDIDX_L);
  // Only the index holder changes; the offset path stays the same
  assign sel_y        = ((prefix_i == CPUAM_PFX_ALT_INDEX) && is_x_indexed)
                        || ((prefix_i == CPUAM_PFX_ALT_IND_IDX) &&
                        is_ind_idx);
  // Rejected before any fetch so no bus cycle is wasted
  assign long_bad     = mem_op_i && am_is_long(eff_mode);
  assign no_fetch     = (eff_mode == AM_INH) ||
                        (eff_mode == AM_IDX0);
  assign accept       = (state_r == ST_IDLE) && start_i;

  assign take_b1      = (state_r == ST_OPND1) && mem_ack_i;
  assign take_b2      = (state_r == ST_OPND2) && mem_ack_i;
  assign take_p1      = (state_r == ST_PTR1) && mem_ack_i;
  assign take_p2      = (state_r == ST_PTR2) && mem_ack_i;

  // Bus request holds until acknowledged
  assign mem_req_o    = (state_r == ST_OPND1) || (state_r == ST_OPND2) ||
                        (state_r == ST_PTR1) || (state_r == ST_PTR2);

  // Address is formed one edge ahead from what the regs will hold next
  assign pc_next      = accept ? pc_i : pc_r;
  assign b1_next      = take_b1 ? mem_rdata_i : b1_r;

  // Pointer and its second byte stay in page zero; the low byte wraps
  always_comb begin
    case (state_nxt)
      ST_OPND1: addr_nxt = pc_next;
      ST_OPND2: addr_nxt = pc_next + CPUAM_ONE;
      ST_PTR1:  addr_nxt = {CPUAM_PAGE_ZERO_HI, b1_next};
      ST_PTR2:  addr_nxt = {CPUAM_PAGE_ZERO_HI,
                            b1_next + CPUAM_ONE_B};
      default:  addr_nxt = CPUAM_RST_ADDR;
    endcase
  end

  // Registered so the memory never sees decode glitches on the address
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      addr_r <= CPUAM_RST_ADDR;
    else
      addr_r <= addr_nxt;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_i) begin
          if (long_bad || no_fetch)
            state_nxt = ST_DONE;
          else
            state_nxt = ST_OPND1;
        end
      end
      ST_OPND1: begin
        if (mem_ack_i) begin
          if (am_two_bytes(mode_r))
            state_nxt = ST_OPND2;
          else if (am_uses_ptr(mode_r))
            state_nxt = ST_PTR1;
          else
            state_nxt = ST_DONE;
        end
      end
      ST_OPND2: begin
        if (mem_ack_i) begin
          if (am_uses_ptr(mode_r))
            state_nxt = ST_PTR1;
          else
            state_nxt = ST_DONE;
        end
      end
      ST_PTR1: begin
        if (mem_ack_i) begin
          if (am_word_ptr(mode_r))
            state_nxt = ST_PTR2;
          else
            state_nxt = ST_DONE;
        end
      end
      ST_PTR2: begin
        if (mem_ack_i)
          state_nxt = ST_DONE;
      end
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Request capture; the core must hold pc and index steady only here
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r  <= AM_INH;
      idx_r   <= CPUAM_RST_BYTE;
      pc_r    <= CPUAM_RST_ADDR;
      bad_r   <= 1'b0;
      use_y_r <= 1'b0;
    end else if (accept) begin
      mode_r  <= eff_mode;
      idx_r   <= sel_y ? y_i : x_i;
      pc_r    <= pc_i;
      bad_r   <= long_bad;
      use_y_r <= sel_y;
    end
  end

  // Fetched bytes; stale bytes of unused slots are harmless
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      b1_r <= CPUAM_RST_BYTE;
      b2_r <= CPUAM_RST_BYTE;
      p1_r <= CPUAM_RST_BYTE;
      p2_r <= CPUAM_RST_BYTE;
    end else begin
      if (take_b1)
        b1_r <= mem_rdata_i;
      if (take_b2)
        b2_r <= mem_rdata_i;
      if (take_p1)
        p1_r <= mem_rdata_i;
      if (take_p2)
        p2_r <= mem_rdata_i;
    end
  end

  cpuam_ea_calc u_ea_calc (
    .mode_i   (mode_r),
    .idx_i    (idx_r),
    .pc_i     (pc_r),
    .b1_i     (b1_r),
    .b2_i     (b2_r),
    .p1_i     (p1_r),
    .p2_i     (p2_r),
    .ea_o     (calc_ea),
    .target_o (calc_target),
    .len_o    (calc_len)
  );

  // Results stand from the done pulse until the next completion
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ea_r        <= CPUAM_RST_ADDR;
      target_r    <= CPUAM_RST_ADDR;
      operand_r   <= CPUAM_RST_BYTE;
      len_r       <= CPUAM_LEN_0;
      illegal_r   <= 1'b0;
      mode_out_r  <= AM_INH;
      use_y_out_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      ea_r        <= bad_r ? CPUAM_RST_ADDR : calc_ea;
      target_r    <= bad_r ? CPUAM_RST_ADDR : calc_target;
      operand_r   <= (mode_r == AM_IMM) ? b1_r : CPUAM_RST_BYTE;
      len_r       <= bad_r ? CPUAM_LEN_0 : calc_len;
      illegal_r   <= bad_r;
      mode_out_r  <= mode_r;
      use_y_out_r <= use_y_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      done_r <= 1'b0;
    else
      done_r <= (state_r == ST_DONE);
  end

  assign busy_o    = (state_r != ST_IDLE);
  assign mem_addr_o = addr_r;
  assign done_o    = done_r;
  assign illegal_o = illegal_r;
  assign use_y_o   = use_y_out_r;
  assign mode_o    = mode_out_r;
  assign ea_o      = ea_r;
  assign target_o  = target_r;
  assign operand_o = operand_r;
  assign len_o     = len_r;

endmodule // cpuam_decoder

// ==== design/cpuam_pkg.sv ====
// Shared modes, states, constants and decode helpers for the address decoder
package cpuam_pkg;

  // Operand addressing modes, short and long forms
  typedef enum logic [4:0] {
    AM_INH      = 5'h00,
    AM_IMM      = 5'h01,
    AM_DIR_S    = 5'h02,
    AM_DIR_L    = 5'h03,
    AM_IDX0     = 5'h04,
    AM_IDX_S    = 5'h05,
    AM_IDX_L    = 5'h06,
    AM_IND_S    = 5'h07,
    AM_IND_L    = 5'h08,
    AM_INDIDX_S = 5'h09,
    AM_INDIDX_L = 5'h0a,
    AM_REL_D    = 5'h0b,
    AM_REL_I    = 5'h0c,
    AM_BIT_D    = 5'h0d,
    AM_BIT_I    = 5'h0e,
    AM_BITREL_D = 5'h0f,
    AM_BITREL_I = 5'h10
  } cpuam_mode_t;

  // Fetch sequencer, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPND1 = 3'b001,
    ST_OPND2 = 3'b011,
    ST_PTR1  = 3'b010,
    ST_PTR2  = 3'b110,
    ST_DONE  = 3'b111
  } cpuam_state_t;

  localparam logic [7:0]  CPUAM_PFX_ALT_INDEX   = 8'h90;
  localparam logic [7:0]  CPUAM_PFX_ALT_IND_IDX = 8'h91;
  localparam logic [7:0]  CPUAM_PFX_INDIRECT    = 8'h92;
  localparam logic [7:0]  CPUAM_PAGE_ZERO_HI    = 8'h00;
  localparam logic [15:0] CPUAM_RST_ADDR        = 16'h0000;
  localparam logic [7:0]  CPUAM_RST_BYTE        = 8'h00;
  localparam logic [15:0] CPUAM_ONE             = 16'h0001;
  localparam logic [15:0] CPUAM_TWO             = 16'h0002;
  localparam logic [7:0]  CPUAM_ONE_B           = 8'h01;
  localparam logic [1:0]  CPUAM_LEN_0           = 2'h0;
  localparam logic [1:0]  CPUAM_LEN_1           = 2'h1;
  localparam logic [1:0]  CPUAM_LEN_2           = 2'h2;

  // Forms that reach the whole 64 Kbyte space
  function automatic logic am_is_long(input cpuam_mode_t m);
    am_is_long = (m == AM_DIR_L) || (m == AM_IDX_L) ||
                 (m == AM_IND_L) || (m == AM_INDIDX_L);
  endfunction

  // Forms with two bytes after the opcode
  function automatic logic am_two_bytes(input cpuam_mode_t m);
    am_two_bytes = (m == AM_DIR_L) || (m == AM_IDX_L) ||
                   (m == AM_BITREL_D) || (m == AM_BITREL_I);
  endfunction

  // Forms that read a pointer from page zero
  function automatic logic am_uses_ptr(input cpuam_mode_t m);
    am_uses_ptr = (m == AM_IND_S) || (m == AM_IND_L) ||
                  (m == AM_INDIDX_S) || (m == AM_INDIDX_L) ||
                  (m == AM_REL_I) || (m == AM_BIT_I) ||
                  (m == AM_BITREL_I);
  endfunction

  // Forms whose pointer is a word
  function automatic logic am_word_ptr(input cpuam_mode_t m);
    am_word_ptr = (m == AM_IND_L) || (m == AM_INDIDX_L);
  endfunction

endpackage

// ==== design/cpuam_ea_calc.sv ====
// Effective address, branch target and operand length from fetched bytes
`timescale 1ns/10ps
module cpuam_ea_calc
  import cpuam_pkg::*;
(
  input  wire logic        [4:0]  mode_i,
  input  wire logic        [7:0]  idx_i,
  input  wire logic        [15:0] pc_i,
  input  wire logic        [7:0]  b1_i,
  input  wire logic        [7:0]  b2_i,
  input  wire logic        [7:0]  p1_i,
  input  wire logic        [7:0]  p2_i,
  output logic             [15:0] ea_o,
  output logic             [15:0] target_o,
  output logic             [1:0]  len_o
);

  cpuam_mode_t m;
  logic [15:0] zp_b1;
  logic [15:0] zp_p1;
  logic [15:0] zp_idx;
  logic [15:0] wd_b;
  logic [15:0] wd_p;
  logic [15:0] rel_off;

  assign m       = cpuam_mode_t'(mode_i);
  assign zp_b1   = {CPUAM_PAGE_ZERO_HI, b1_i};
  assign zp_p1   = {CPUAM_PAGE_ZERO_HI, p1_i};
  assign zp_idx  = {CPUAM_PAGE_ZERO_HI, idx_i};
  assign wd_b    = {b1_i, b2_i};
  assign wd_p    = {p1_i, p2_i};
  // Offset source: direct after opcode, via pointer, or second byte
  assign rel_off = (m == AM_REL_D) ? {{8{b1_i[7]}}, b1_i} :
                   (m == AM_REL_I) ? {{8{p1_i[7]}}, p1_i} :
                                     {{8{b2_i[7]}}, b2_i};

  always_comb begin
    ea_o     = CPUAM_RST_ADDR;
    target_o = CPUAM_RST_ADDR;
    len_o    = CPUAM_LEN_1;
    case (m)
      AM_INH:      len_o = CPUAM_LEN_0;
      AM_IMM:      len_o = CPUAM_LEN_1;
      AM_DIR_S:    ea_o  = zp_b1;
      AM_DIR_L: begin
        ea_o  = wd_b;
        len_o = CPUAM_LEN_2;
      end
      AM_IDX0: begin
        ea_o  = zp_idx;
        len_o = CPUAM_LEN_0;
      end
      AM_IDX_S:    ea_o  = zp_b1 + zp_idx;
      AM_IDX_L: begin
        // Carry out of bit 15 is dropped on purpose
        ea_o  = wd_b + zp_idx;
        len_o = CPUAM_LEN_2;
      end
      AM_IND_S:    ea_o  = zp_p1;
      AM_IND_L:    ea_o  = wd_p;
      AM_INDIDX_S: ea_o  = zp_p1 + zp_idx;
      AM_INDIDX_L: ea_o  = wd_p + zp_idx;
      AM_REL_D,
      AM_REL_I: begin
        ea_o     = zp_b1;
        target_o = pc_i + CPUAM_ONE + rel_off;
      end
      AM_BIT_D:    ea_o  = zp_b1;
      AM_BIT_I:    ea_o  = zp_p1;
      AM_BITREL_D,
      AM_BITREL_I: begin
        ea_o     = (m == AM_BITREL_D) ? zp_b1 : zp_p1;
        target_o = pc_i + CPUAM_TWO + rel_off;
        len_o    = CPUAM_LEN_2;
      end
      default: begin
        ea_o     = CPUAM_RST_ADDR;
        target_o = CPUAM_RST_ADDR;
        len_o    = CPUAM_LEN_0;
      end
    endcase
  end

endmodule // cpuam_ea_calc

// ==== testbench/cpuam_decoder_properties.sv ====
// Concurrent checks on the ports of the addressing mode decoder
`timescale 1ns/10ps
module cpuam_decoder_properties
  import cpuam_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        start_i,
  input wire logic [4:0]  mode_i,
  input wire logic        mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        illegal_o,
  input wire logic        use_y_o,
  input wire logic [4:0]  mode_o,
  input wire logic [15:0] ea_o,
  input wire logic [1:0]  len_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire take = start_i && !busy_o;

  req_idle_a: assert property (
    !busy_o |-> !mem_req_o) else $error("memory read outside an operation");
  req_hold_a: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped or moved before ack");
  done_pulse_a: assert property (
    done_o |=> !done_o) else $error("done longer than one cycle");
  op_bound_a: assert property (
    take |-> ##[2:40] done_o) else $error("operation never completed");
  inh_fast_a: assert property (
    take && mode_i == AM_INH |=> busy_o && !mem_req_o ##1
    done_o && len_o == CPUAM_LEN_0) else $error("inherent op fetched bytes");
  imm_len_a: assert property (
    done_o && mode_o == AM_IMM |-> len_o == CPUAM_LEN_1)
    else $error("immediate length wrong");
  long_len_a: assert property (
    done_o && !illegal_o && mode_o inside {AM_DIR_L, AM_IDX_L}
    |-> len_o == CPUAM_LEN_2) else $error("long form length wrong");
  page_zero_a: assert property (
    done_o && mode_o inside {AM_DIR_S, AM_IDX0, AM_IND_S, AM_BIT_D, AM_BIT_I}
    |-> ea_o[15:8] == 8'h00) else $error("short form left page zero");
  short_idx_a: assert property (
    done_o && mode_o inside {AM_IDX_S, AM_INDIDX_S} |-> ea_o <= 16'h01fe)
    else $error("short indexed address out of range");
  illegal_a: assert property (
    done_o && illegal_o |-> len_o == CPUAM_LEN_0 && ea_o == 16'h0000)
    else $error("refused op left results");
  use_y_a: assert property (
    done_o && use_y_o |->
    mode_o inside {AM_IDX0, AM_IDX_S, AM_IDX_L, AM_INDIDX_S, AM_INDIDX_L})
    else $error("second index register on a non indexed mode");
endmodule // cpuam_decoder_properties

// ==== testbench/cpuam_mem_model.sv ====
// Behavioural program and data memory with optional wait states
`timescale 1ns/10ps
module cpuam_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic [7:0]       mem_rdata_o
);
  logic [1:0] wait_r;
  logic [7:0] last_r;
  // Slow mode holds every read for two wait cycles
  assign mem_ack_o   = mem_req_i && (!slow_i || wait_r == 2'h2);
  // Data is only good with ack, so never leave the last byte standing
  assign mem_rdata_o = mem_ack_o ?
                       (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h5a) : ~last_r;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 2'h0;
      last_r <= 8'h00;
    end else begin
      wait_r <= (mem_req_i && !mem_ack_o) ? wait_r + 2'h1 : 2'h0;
      if (mem_ack_o) last_r <= mem_rdata_o;
    end
  end
endmodule // cpuam_mem_model

// ==== testbench/cpuam_decoder_test.sv ====
// Self-checking bench for the addressing mode decoder
`timescale 1ns/10ps
module cpuam_decoder_test
  import cpuam_pkg::*;
();
  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        start_i   = 1'b0;
  logic [4:0]  mode_i    = 5'h00;
  logic [7:0]  prefix_i  = 8'h00;
  logic        mem_op_i  = 1'b0;
  logic [15:0] pc_i      = 16'h0000;
  logic [7:0]  x_i       = 8'h00;
  logic [7:0]  y_i       = 8'h00;
  logic        slow      = 1'b0;
  logic        mem_req_o, mem_ack_i, busy_o, done_o, illegal_o, use_y_o;
  logic [15:0] mem_addr_o, ea_o, target_o;
  logic [7:0]  mem_rdata_i, operand_o, b1, b2, p1, p2;
  logic [4:0]  mode_o;
  logic [1:0]  len_o;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  cpuam_decoder i_cpuam_decoder (.sys_clk_i, .nrst_i, .start_i, .mode_i,
    .prefix_i, .mem_op_i, .pc_i, .x_i, .y_i, .mem_req_o, .mem_addr_o,
    .mem_rdata_i, .mem_ack_i, .busy_o, .done_o, .illegal_o, .use_y_o,
    .mode_o, .ea_o, .target_o, .operand_o, .len_o);
  cpuam_mem_model i_cpuam_mem_model (.sys_clk_i, .nrst_i, .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  function automatic logic [7:0] mb(input logic [15:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [15:0] sx(input logic [7:0] b);
    sx = {{8{b[7]}}, b};
  endfunction

  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  // Entered just after an edge; the next start may share the done cycle
  task automatic op(input cpuam_mode_t m, input logic [7:0] pf,
                    input logic mo, input logic [15:0] pc);
    int n;
    n = 0;
    start_i = 1'b1;
    mode_i = m;
    prefix_i = pf;
    mem_op_i = mo;
    pc_i = pc;
    @(posedge sys_clk_i);
    #1;
    start_i = 1'b0;
    while (done_o !== 1'b1 && n < 60) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("done", {15'h0000, done_o}, 16'h0001);
    b1 = mb(pc);
    b2 = mb(pc + 16'h0001);
    p1 = mb({8'h00, b1});
    p2 = mb({8'h00, b1 + 8'h01});
  endtask

  task automatic res(input cpuam_mode_t m, input logic [15:0] ea, tg,
                     input logic [1:0] ln);
    chk("mode", {11'h000, mode_o}, {11'h000, m});
    chk("ea", ea_o, ea);
    chk("target", target_o, tg);
    chk("len", {14'h0000, len_o}, {14'h0000, ln});
  endtask

  task automatic t_plain;
    op(AM_INH, 8'h00, 1'b0, 16'h4000);
    res(AM_INH, 16'h0000, 16'h0000, CPUAM_LEN_0);
    op(AM_IMM, 8'h00, 1'b0, 16'h4001);
    res(AM_IMM, 16'h0000, 16'h0000, CPUAM_LEN_1);
    chk("operand", {8'h00, operand_o}, {8'h00, b1});
    slow = 1'b1;
    op(AM_DIR_S, 8'h00, 1'b0, 16'h2345);
    res(AM_DIR_S, {8'h00, b1}, 16'h0000, CPUAM_LEN_1);
    op(AM_DIR_L, 8'h00, 1'b0, 16'h2346);
    res(AM_DIR_L, {b1, b2}, 16'h0000, CPUAM_LEN_2);
    slow = 1'b0;
  endtask

  task automatic t_index;
    x_i = 8'hff;
    op(AM_IDX0, 8'h00, 1'b0, 16'h1000);
    res(AM_IDX0, 16'h00ff, 16'h0000, CPUAM_LEN_0);
    op(AM_IDX_S, 8'h00, 1'b0, 16'h00a5);
    res(AM_IDX_S, 16'h01fe, 16'h0000, CPUAM_LEN_1);
    op(AM_IDX_L, 8'h00, 1'b0, 16'h00a5);
    res(AM_IDX_L, 16'h00fb, 16'h0000, CPUAM_LEN_2);
  endtask

  // Slow memory here so that pointer reads also wait
  task automatic t_indir;
    slow = 1'b1;
    op(AM_IND_S, 8'h00, 1'b0, 16'h3000);
    res(AM_IND_S, {8'h00, p1}, 16'h0000, CPUAM_LEN_1);
    op(AM_IND_L, 8'h00, 1'b0, 16'h3001);
    res(AM_IND_L, {p1, p2}, 16'h0000, CPUAM_LEN_1);
    op(AM_INDIDX_S, 8'h00, 1'b0, 16'h3002);
    res(AM_INDIDX_S, {8'h00, p1} + 16'h00ff, 16'h0000, CPUAM_LEN_1);
    op(AM_INDIDX_L, 8'h00, 1'b0, 16'h00a5);
    res(AM_INDIDX_L, 16'ha659, 16'h0000, CPUAM_LEN_1);
    slow = 1'b0;
  endtask

  task automatic t_rel;
    op(AM_REL_D, 8'h00, 1'b0, 16'h5080);
    chk("target", target_o, 16'h5081 + sx(b1));
    op(AM_REL_I, 8'h00, 1'b0, 16'h5081);
    res(AM_REL_I, {8'h00, b1}, 16'h5082 + sx(p1), CPUAM_LEN_1);
    op(AM_BIT_D, 8'h00, 1'b0, 16'h5082);
    res(AM_BIT_D, {8'h00, b1}, 16'h0000, CPUAM_LEN_1);
    op(AM_BIT_I, 8'h00, 1'b0, 16'h5083);
    res(AM_BIT_I, {8'h00, p1}, 16'h0000, CPUAM_LEN_1);
    op(AM_BITREL_D, 8'h00, 1'b0, 16'h5084);
    res(AM_BITREL_D, {8'h00, b1}, 16'h5086 + sx(b2), CPUAM_LEN_2);
    op(AM_BITREL_I, 8'h00, 1'b0, 16'h5085);
    res(AM_BITREL_I, {8'h00, p1}, 16'h5087 + sx(b2), CPUAM_LEN_2);
  endtask

  task automatic t_prefix;
    x_i = 8'h10;
    y_i = 8'h20;
    op(AM_IDX_S, CPUAM_PFX_ALT_INDEX, 1'b0, 16'h6000);
    res(AM_IDX_S, {8'h00, b1} + 16'h0020, 16'h0000, CPUAM_LEN_1);
    chk("use_y", {15'h0000, use_y_o}, 16'h0001);
    op(AM_DIR_L, CPUAM_PFX_INDIRECT, 1'b0, 16'h6001);
    res(AM_IND_L, {p1, p2}, 16'h0000, CPUAM_LEN_1);
    op(AM_IDX_S, CPUAM_PFX_INDIRECT, 1'b0, 16'h6002);
    res(AM_INDIDX_S, {8'h00, p1} + 16'h0010, 16'h0000, CPUAM_LEN_1);
    chk("use_y", {15'h0000, use_y_o}, 16'h0000);
    op(AM_REL_D, CPUAM_PFX_INDIRECT, 1'b0, 16'h6003);
    res(AM_REL_I, {8'h00, b1}, 16'h6004 + sx(p1), CPUAM_LEN_1);
    op(AM_IDX_L, CPUAM_PFX_ALT_IND_IDX, 1'b0, 16'h6004);
    res(AM_INDIDX_L, {p1, p2} + 16'h0020, 16'h0000, CPUAM_LEN_1);
    chk("use_y", {15'h0000, use_y_o}, 16'h0001);
  endtask

  task automatic t_illegal;
    op(AM_DIR_L, 8'h00, 1'b1, 16'h7000);
    chk("illegal", {15'h0000, illegal_o}, 16'h0001);
    res(AM_DIR_L, 16'h0000, 16'h0000, CPUAM_LEN_0);
    op(AM_DIR_S, 8'h00, 1'b1, 16'h7001);
    chk("illegal", {15'h0000, illegal_o}, 16'h0000);
    res(AM_DIR_S, {8'h00, b1}, 16'h0000, CPUAM_LEN_1);
    op(AM_IDX_L, CPUAM_PFX_INDIRECT, 1'b1, 16'h7002);
    chk("illegal", {15'h0000, illegal_o}, 16'h0001);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("busy", {15'h0000, busy_o}, 16'h0000);
    nrst_i = 1'b1;
    t_plain;
    t_index;
    t_indir;
    t_rel;
    t_prefix;
    t_illegal;
    end_sim;
  end

  // Whole run is some 120 cycles; allow fifty times that
  initial begin
    #240000;
    n_mismatch++;
    end_sim;
  end
endmodule // cpuam_decoder_test

bind cpuam_decoder cpuam_decoder_properties i_cpuam_decoder_properties (
  .sys_clk_i, .nrst_i, .start_i, .mode_i, .mem_req_o, .mem_addr_o,
  .mem_ack_i, .busy_o, .done_o, .illegal_o, .use_y_o, .mode_o, .ea_o,
  .len_o);
